// ==== pkg/hpm_consts.svh ====
// constants of the halt power mode clock gate
//------------------------------------------------------------------------------
// Notes on behaviour
// - mode applied only when halt executes
// - mode field is watchdog mode bits 4:3
// - mode change needs DBh unlock first
// - run mode keeps every clock during halt
// - light idle: oscillator only, at T4
// - counter-awake idle: oscillator, counter, clock out
// - stop mode: everything off at T4
// - halted indicator low at T4 of halt
// - halt left on reset or accepted interrupt
// - interrupts sampled at T4 of no-op
// - maskable interrupt needs low request and enable
// - stopped clock restarts on reset or interrupt
// - after reset execution starts at 0000H
// - stop wake waits 2^14+2.5 clocks
// - one no-op, then sleep again if untaken
//------------------------------------------------------------------------------
`ifndef HPM_CONSTS_SVH
`define HPM_CONSTS_SVH

// register map, byte addresses on the apb
`define HPM_ADDR_W          12
`define HPM_MODE_REG_ADDR   12'h000
`define HPM_CMD_REG_ADDR    12'h004
`define HPM_STAT_REG_ADDR   12'h008

// watchdog mode register layout
`define HPM_MODE_LSB        3
`define HPM_MODE_MSB        4
`define HPM_MODE_REG_RST    8'h18
`define HPM_UNLOCK_KEY      8'hdb

// sleep mode codes
`define HPM_MODE_IDLE_LIGHT 2'b00
`define HPM_MODE_IDLE_CTR   2'b01
`define HPM_MODE_STOP       2'b10
`define HPM_MODE_RUN        2'b11

// restart address after reset
`define HPM_RESTART_ADDR    16'h0000

// warm-up time in half system clocks (2^14 + 2.5 cycles), rounded up to cycles
`define HPM_WARMUP_HALF_CYC ((2**14) * 2 + 5)
`define HPM_WARMUP_CYC      ((`HPM_WARMUP_HALF_CYC + 1) / 2)

`endif

// ==== pkg/hpm_pkg.sv ====
// types of the halt power mode clock gate
package hpm_pkg;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_HALT_RUN,
    ST_SLEEP,
    ST_WARMUP,
    ST_NOP
  } hpm_state_type;

  typedef logic [1:0] hpm_mode_type;

  // clock enables; each one is a registered level for a low-holding gate cell
  typedef struct packed {
    logic osc;
    logic clock_out;
    logic cpu;
    logic counter;
    logic periph;
  } hpm_gate_type;

endpackage : hpm_pkg

// ==== sim/hpm_ext_model.sv ====
// far side model: interrupt pins and the reset circuit
module hpm_ext_model (
  // clock
  input  wire logic pclk,
  // commands from the bench
  input  wire logic irq_req,
  input  wire logic nmi_req,
  input  wire logic rst_req,
  // acceptance seen from the block
  input  wire logic irq_take,
  input  wire logic nmi_take,
  // pins
  output logic      irq_n,
  output logic      nmi_n,
  output logic      presetn
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [4:0] hold_ff = 5'h14;

  initial begin
    irq_n   = 1'b1;
    nmi_n   = 1'b1;
    presetn = 1'b0;
  end

  // pin low while the bench requests, driven high in the cycle after the block accepts it
  always @(posedge pclk) begin
    irq_n <= irq_take ? 1'b1 : !irq_req;
    nmi_n <= nmi_take ? 1'b1 : !nmi_req;
  end

  // a reset request stretches to four clocks, above the three-clock minimum
  always @(posedge pclk) begin
    if (rst_req) begin
      hold_ff <= 5'h04;
    end else if (hold_ff != 5'h00) begin
      hold_ff <= hold_ff - 5'h01;
    end
    presetn <= (hold_ff <= 5'h01) && !rst_req;
  end
endmodule // hpm_ext_model

// ==== sim/tb.sv ====
// self-checking bench of the halt power mode clock gate
`include "hpm_consts.svh"

module tb;
  import hpm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int WU = 8;

  logic        pclk       = 1'b0;
  logic [11:0] paddr      = 12'h000;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [31:0] pwdata     = 32'h0;
  logic        halt_fetch = 1'b0;
  logic        t4_strobe  = 1'b0;
  logic        int_enable = 1'b0;
  logic        irq_req    = 1'b0;
  logic        nmi_req    = 1'b0;
  logic        rst_req    = 1'b0;
  logic        presetn, irq_n, nmi_n, pready, pslverr, halted_n, irq_take, nmi_take;
  logic [31:0] prdata, rd;
  logic [15:0] restart_addr;
  hpm_gate_type gate;
  int          bad_count  = 0;
  int          check_count = 0;

  // the clock stands for the on-chip generator, so every sleep mode is legal
  always #12.5 pclk = ~pclk;

  hpm_top #(.WARMUP_CYCLES(WU)) dut_u (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .halt_fetch(halt_fetch), .t4_strobe(t4_strobe), .int_enable(int_enable),
    .irq_n(irq_n), .nmi_n(nmi_n), .gate(gate), .halted_n(halted_n),
    .irq_take(irq_take), .nmi_take(nmi_take), .restart_addr(restart_addr));

  hpm_ext_model ext_u (
    .pclk(pclk), .irq_req(irq_req), .nmi_req(nmi_req), .rst_req(rst_req),
    .irq_take(irq_take), .nmi_take(nmi_take), .irq_n(irq_n), .nmi_n(nmi_n),
    .presetn(presetn));

  //----------------------------------------------------------------------------
  // shared tasks
  //----------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic give_verdict();
    if (bad_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     input logic err);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    chk({31'h0, pslverr}, {31'h0, err}, "pslverr");
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic set_mode(input logic [1:0] m);
    apb(`HPM_CMD_REG_ADDR, 1'b1, 32'hdb, 1'b0);
    apb(`HPM_MODE_REG_ADDR, 1'b1, {27'h0, m, 3'h0}, 1'b0);
  endtask

  task automatic do_halt(input logic [4:0] exp);
    @(posedge pclk) halt_fetch <= 1'b1;
    @(posedge pclk) halt_fetch <= 1'b0;
    #1 chk({31'h0, halted_n}, 32'h0, "halted_n on halt");
    chk({27'h0, gate}, {27'h0, exp}, "gate on halt");
  endtask

  task automatic pulse_t4();
    @(posedge pclk) t4_strobe <= 1'b1;
    @(posedge pclk) t4_strobe <= 1'b0;
    #1;
  endtask

  task automatic wait_gate(input logic [4:0] exp, output int n);
    n = 0;
    while (gate !== exp && n < 60) begin
      @(posedge pclk);
      n++;
    end
    chk({27'h0, gate}, {27'h0, exp}, "gate wait");
    if (n >= 60) give_verdict();
  endtask

  //----------------------------------------------------------------------------
  // scenarios
  //----------------------------------------------------------------------------
  task automatic t_reset();
    chk({27'h0, gate}, 32'h1f, "gate reset");
    chk({31'h0, halted_n}, 32'h1, "halted_n reset");
    chk({16'h0, restart_addr}, 32'h0, "restart address");
    apb(`HPM_MODE_REG_ADDR, 1'b0, 32'h0, 1'b0);
    chk(rd, 32'h18, "mode reset value");
    apb(`HPM_STAT_REG_ADDR, 1'b0, 32'h0, 1'b0);
    chk(rd, 32'h30, "status reset value");
  endtask

  task automatic t_lock();
    apb(`HPM_MODE_REG_ADDR, 1'b1, 32'h07, 1'b0);
    apb(`HPM_MODE_REG_ADDR, 1'b0, 32'h0, 1'b0);
    chk(rd, 32'h1f, "field kept without unlock");
    apb(12'h00c, 1'b0, 32'h0, 1'b1);
    chk(rd, 32'h0, "unmapped read");
    apb(`HPM_CMD_REG_ADDR, 1'b1, 32'hdb, 1'b0);
    apb(`HPM_CMD_REG_ADDR, 1'b0, 32'h0, 1'b0);
    chk(rd, 32'h1, "unlock armed");
    apb(`HPM_CMD_REG_ADDR, 1'b1, 32'h00, 1'b0);
    apb(`HPM_MODE_REG_ADDR, 1'b1, 32'h00, 1'b0);
    apb(`HPM_MODE_REG_ADDR, 1'b0, 32'h0, 1'b0);
    chk(rd, 32'h18, "disarmed unlock");
    set_mode(`HPM_MODE_STOP);
    apb(`HPM_MODE_REG_ADDR, 1'b0, 32'h0, 1'b0);
    chk(rd, 32'h10, "mode after unlock");
    chk({27'h0, gate}, 32'h1f, "no gating on write");
  endtask

  task automatic t_modes();
    logic [1:0] m[4] = '{2'b11, 2'b00, 2'b01, 2'b10};
    logic [4:0] g[4] = '{5'h1f, 5'h10, 5'h1a, 5'h00};
    int n;
    int_enable <= 1'b1;
    foreach (m[i]) begin
      set_mode(m[i]);
      do_halt(g[i]);
      irq_req <= 1'b1;
      if (m[i] == `HPM_MODE_STOP) begin
        wait_gate(5'h10, n);
        wait_gate(5'h1f, n);
        chk({31'h0, n >= WU - 1 && n <= WU + 1}, 32'h1, "warm-up length");
      end else begin
        if (m[i] == `HPM_MODE_RUN) repeat (5) @(posedge pclk);
        wait_gate(5'h1f, n);
      end
      pulse_t4();
      chk({31'h0, irq_take}, 32'h1, "irq accepted");
      chk({31'h0, halted_n}, 32'h1, "halt left");
      irq_req <= 1'b0;
      repeat (6) @(posedge pclk);
    end
  endtask

  task automatic t_resleep();
    int n;
    int_enable <= 1'b0;
    set_mode(`HPM_MODE_RUN);
    do_halt(5'h1f);
    apb(`HPM_STAT_REG_ADDR, 1'b0, 32'h0, 1'b0);
    chk(rd, 32'h39, "status in run halt");
    irq_req <= 1'b1;
    repeat (5) @(posedge pclk);
    pulse_t4();
    chk({31'h0, irq_take}, 32'h0, "masked irq in run halt");
    chk({31'h0, halted_n}, 32'h0, "run halt kept");
    irq_req <= 1'b0;
    nmi_req <= 1'b1;
    repeat (6) @(posedge pclk);
    pulse_t4();
    chk({31'h0, nmi_take}, 32'h1, "nmi leaves run halt");
    nmi_req <= 1'b0;
    repeat (6) @(posedge pclk);
    set_mode(`HPM_MODE_IDLE_LIGHT);
    do_halt(5'h10);
    irq_req <= 1'b1;
    wait_gate(5'h1f, n);
    pulse_t4();
    chk({31'h0, irq_take}, 32'h0, "masked irq refused");
    irq_req <= 1'b0;
    repeat (6) @(posedge pclk);
    pulse_t4();
    chk({27'h0, gate}, 32'h10, "sleep again");
    chk({31'h0, halted_n}, 32'h0, "still halted");
    nmi_req <= 1'b1;
    wait_gate(5'h1f, n);
    pulse_t4();
    chk({31'h0, nmi_take}, 32'h1, "nmi accepted");
    nmi_req <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask

  task automatic t_rst_warm();
    int n;
    set_mode(`HPM_MODE_STOP);
    do_halt(5'h00);
    irq_req <= 1'b1;
    wait_gate(5'h10, n);
    irq_req <= 1'b0;
    @(posedge pclk) rst_req <= 1'b1;
    @(posedge pclk) rst_req <= 1'b0;
    wait (presetn === 1'b0);
    #1 chk({27'h0, gate}, 32'h1f, "gate in reset");
    wait (presetn === 1'b1);
    @(posedge pclk);
    #1 chk({27'h0, gate}, 32'h1f, "gate after reset");
    chk({31'h0, halted_n}, 32'h1, "released by reset");
    chk({16'h0, restart_addr}, 32'h0, "restart address");
    apb(`HPM_MODE_REG_ADDR, 1'b0, 32'h0, 1'b0);
    chk(rd, 32'h18, "mode restored");
  endtask

  //----------------------------------------------------------------------------
  // main sequence and watchdog
  //----------------------------------------------------------------------------
  initial begin
    wait (presetn === 1'b1);
    @(posedge pclk);
    t_reset();
    t_lock();
    t_modes();
    t_resleep();
    t_rst_warm();
    give_verdict();
  end

  // the tests need some three hundred cycles; over thirty times that means a hang
  initial begin
    repeat (10000) @(posedge pclk);
    bad_count++;
    give_verdict();
  end
endmodule // tb

// ==== src/hpm_sync.sv ====
// three-stage pin synchroniser with agreement filter
module hpm_sync #(
  parameter int   WIDTH   = 1,
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // pins and clean levels
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= {WIDTH{RST_VAL}};
      s2_ff <= {WIDTH{RST_VAL}};
      s3_ff <= {WIDTH{RST_VAL}};
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // a bit changes only once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          dout[i] <= RST_VAL;
        end else if (s2_ff[i] == s3_ff[i]) begin
          dout[i] <= s3_ff[i];
        end
      end
    end
  endgenerate

endmodule // hpm_sync

// ==== src/hpm_top.sv ====
// halt power mode controller with apb registers and clock gate enables
`include "hpm_consts.svh"

module hpm_top #(
  parameter int WARMUP_CYCLES = `HPM_WARMUP_CYC
) (
  // clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // apb slave
  input  wire logic [`HPM_ADDR_W-1:0]    paddr,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // processor core handshake
  input  wire logic                      halt_fetch,
  input  wire logic                      t4_strobe,
  input  wire logic                      int_enable,
  // interrupt pins, active low, asynchronous
  input  wire logic                      irq_n,
  input  wire logic                      nmi_n,
  // clock gating and core control
  output hpm_pkg::hpm_gate_type          gate,
  output logic                           halted_n,
  output logic                           irq_take,
  output logic                           nmi_take,
  output logic      [15:0]               restart_addr
);
  import hpm_pkg::*;

  //----------------------------------------------------------------------------
  // pin synchronisers
  //----------------------------------------------------------------------------
  logic [1:0] pins_sync;
  logic       irq_s;
  logic       nmi_s;

  hpm_sync #(
    .WIDTH   (2),
    .RST_VAL (1'b1)
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .din   ({nmi_n, irq_n}),
    .dout  (pins_sync)
  );

  assign irq_s = ~pins_sync[0];
  assign nmi_s = ~pins_sync[1];

  //----------------------------------------------------------------------------
  // apb slave: one wait state, effect at the edge that sees pready high
  //----------------------------------------------------------------------------
  logic        pready_ff;
  logic [31:0] prdata_ff;
  logic        pslverr_ff;
  logic        acc_first;
  logic        wr_done;
  logic        addr_ok;

  assign acc_first = psel & penable & ~pready_ff;
  assign wr_done   = psel & penable & pready_ff & pwrite;
  assign addr_ok   = (paddr == `HPM_MODE_REG_ADDR) | (paddr == `HPM_CMD_REG_ADDR) |
                     (paddr == `HPM_STAT_REG_ADDR);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= acc_first;
    end
  end

  //----------------------------------------------------------------------------
  // unlock and watchdog mode register
  //----------------------------------------------------------------------------
  logic       unlock_ff;
  logic [7:0] mode_reg_ff;
  logic       wr_mode;
  logic       wr_cmd;

  assign wr_mode = wr_done & ~pslverr_ff & (paddr == `HPM_MODE_REG_ADDR);
  assign wr_cmd  = wr_done & ~pslverr_ff & (paddr == `HPM_CMD_REG_ADDR);

  // a command write other than the key, or the mode write itself, spends the unlock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_ff <= 1'b0;
    end else if (wr_cmd) begin
      unlock_ff <= (pwdata[7:0] == `HPM_UNLOCK_KEY);
    end else if (wr_mode) begin
      unlock_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg_ff <= `HPM_MODE_REG_RST;
    end else if (wr_mode) begin
      mode_reg_ff[7:`HPM_MODE_MSB+1] <= pwdata[7:`HPM_MODE_MSB+1];
      mode_reg_ff[`HPM_MODE_LSB-1:0] <= pwdata[`HPM_MODE_LSB-1:0];
      if (unlock_ff) begin
        mode_reg_ff[`HPM_MODE_MSB:`HPM_MODE_LSB] <= pwdata[`HPM_MODE_MSB:`HPM_MODE_LSB];
      end
    end
  end

  hpm_mode_type sleep_mode_field;
  assign sleep_mode_field = mode_reg_ff[`HPM_MODE_MSB:`HPM_MODE_LSB];

  //----------------------------------------------------------------------------
  // halt state machine
  //----------------------------------------------------------------------------
  hpm_state_type state_ff;
  hpm_state_type nxt_state;
  hpm_mode_type  halt_mode_ff;
  hpm_mode_type  nxt_halt_mode;
  logic [14:0]   warm_cnt_ff;
  logic          halted_n_ff;
  logic          nxt_halted_n;
  logic          irq_take_ff;
  logic          nmi_take_ff;
  logic          take_nmi;
  logic          take_irq;
  logic          wake;
  logic          warm_done;

  // nmi has priority and cannot be masked
  assign take_nmi  = nmi_s;
  assign take_irq  = irq_s & int_enable & ~nmi_s;
  assign wake      = nmi_s | irq_s;
  assign warm_done = (warm_cnt_ff == 15'(WARMUP_CYCLES - 1));

  always_comb begin
    nxt_state     = state_ff;
    nxt_halt_mode = halt_mode_ff;
    nxt_halted_n  = halted_n_ff;
    case (state_ff)
      ST_RUN: begin
        if (halt_fetch) begin
          nxt_halted_n  = 1'b0;
          nxt_halt_mode = sleep_mode_field;
          nxt_state     = (sleep_mode_field == `HPM_MODE_RUN) ? ST_HALT_RUN : ST_SLEEP;
        end
      end
      ST_HALT_RUN, ST_NOP: begin
        if (t4_strobe) begin
          if (take_nmi | take_irq) begin
            nxt_state    = ST_RUN;
            nxt_halted_n = 1'b1;
          end else if (state_ff == ST_NOP) begin
            nxt_state = ST_SLEEP;
          end
        end
      end
      ST_SLEEP: begin
        if (wake) begin
          nxt_state = (halt_mode_ff == `HPM_MODE_STOP) ? ST_WARMUP : ST_NOP;
        end
      end
      ST_WARMUP: begin
        if (warm_done) begin
          nxt_state = ST_NOP;
        end
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff     <= ST_RUN;
      halt_mode_ff <= `HPM_MODE_RUN;
      halted_n_ff  <= 1'b1;
    end else begin
      state_ff     <= nxt_state;
      halt_mode_ff <= nxt_halt_mode;
      halted_n_ff  <= nxt_halted_n;
    end
  end

  // reset drops the count wherever it stood
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warm_cnt_ff <= 15'h0000;
    end else if (state_ff == ST_WARMUP && !warm_done) begin
      warm_cnt_ff <= warm_cnt_ff + 15'h0001;
    end else begin
      warm_cnt_ff <= 15'h0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_take_ff <= 1'b0;
      nmi_take_ff <= 1'b0;
    end else begin
      irq_take_ff <= (state_ff == ST_HALT_RUN || state_ff == ST_NOP) & t4_strobe & take_irq;
      nmi_take_ff <= (state_ff == ST_HALT_RUN || state_ff == ST_NOP) & t4_strobe & take_nmi;
    end
  end

  //----------------------------------------------------------------------------
  // clock enables
  //----------------------------------------------------------------------------
  // enables change on pclk edges, or at once when presetn falls; the downstream gate cell latches them
  // in the low phase, so a stopped clock sits low and never emits a runt pulse
  function automatic hpm_gate_type gate_of(hpm_state_type st, hpm_mode_type md);
    hpm_gate_type g;
    g = '{osc: 1'b1, clock_out: 1'b1, cpu: 1'b1, counter: 1'b1, periph: 1'b1};
    if (st == ST_WARMUP) begin
      g = '{osc: 1'b1, clock_out: 1'b0, cpu: 1'b0, counter: 1'b0, periph: 1'b0};
    end else if (st == ST_SLEEP) begin
      case (md)
        `HPM_MODE_IDLE_LIGHT: g = '{osc: 1'b1, clock_out: 1'b0, cpu: 1'b0, counter: 1'b0,
                                    periph: 1'b0};
        `HPM_MODE_IDLE_CTR:   g = '{osc: 1'b1, clock_out: 1'b1, cpu: 1'b0, counter: 1'b1,
                                    periph: 1'b0};
        `HPM_MODE_STOP:       g = '{osc: 1'b0, clock_out: 1'b0, cpu: 1'b0, counter: 1'b0,
                                    periph: 1'b0};
        default:              g = g;
      endcase
    end
    return g;
  endfunction

  hpm_gate_type gate_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_ff <= '{osc: 1'b1, clock_out: 1'b1, cpu: 1'b1, counter: 1'b1, periph: 1'b1};
    end else begin
      gate_ff <= gate_of(nxt_state, nxt_halt_mode);
    end
  end

  //----------------------------------------------------------------------------
  // restart address and register read data
  //----------------------------------------------------------------------------
  logic [15:0] restart_addr_ff;
  logic [31:0] rd_mux;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restart_addr_ff <= `HPM_RESTART_ADDR;
    end else begin
      restart_addr_ff <= `HPM_RESTART_ADDR;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `HPM_MODE_REG_ADDR: rd_mux = {24'h00_0000, mode_reg_ff};
      `HPM_CMD_REG_ADDR:  rd_mux = {31'h0000_0000, unlock_ff};
      `HPM_STAT_REG_ADDR: rd_mux = {26'h000_0000, halt_mode_ff, ~halted_n_ff, state_ff};
      default:            rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (acc_first) begin
      prdata_ff  <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_ff <= ~addr_ok;
    end else begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end
  end

  assign prdata       = prdata_ff;
  assign pready       = pready_ff;
  assign pslverr      = pslverr_ff;
  assign gate         = gate_ff;
  assign halted_n     = halted_n_ff;
  assign irq_take     = irq_take_ff;
  assign nmi_take     = nmi_take_ff;
  assign restart_addr = restart_addr_ff;

  //----------------------------------------------------------------------------
  // assertions
  //----------------------------------------------------------------------------
  a_mode_on_halt: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == ST_RUN && halt_fetch) |=> (halt_mode_ff == $past(sleep_mode_field)))
    else $error("halt did not latch the mode field");

  a_mode_locked: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_mode && !unlock_ff) |=> $stable(sleep_mode_field))
    else $error("mode field changed without unlock");

  a_halt_ind: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == ST_RUN && halt_fetch) |=> !halted_n ##0 (gate.cpu == 1'b1 ||
      state_ff == ST_SLEEP))
    else $error("halted indicator not low after halt");

  a_run_clocks: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == ST_HALT_RUN) |-> (gate == 5'b11111))
    else $error("clock gated during run-mode halt");

  a_light_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == ST_SLEEP && halt_mode_ff == `HPM_MODE_IDLE_LIGHT) |-> (gate == 5'b10000))
    else $error("light idle gating wrong");

  a_ctr_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == ST_SLEEP && halt_mode_ff == `HPM_MODE_IDLE_CTR) |-> (gate == 5'b11010))
    else $error("counter idle gating wrong");

  a_stop_all: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == ST_SLEEP && halt_mode_ff == `HPM_MODE_STOP) |-> (gate == 5'b00000))
    else $error("stop mode left a clock running");

  a_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == ST_HALT_RUN && t4_strobe && !nmi_s && !int_enable) |=>
      (state_ff == ST_HALT_RUN && !irq_take))
    else $error("masked interrupt was accepted");

  a_take_release: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_take || nmi_take) |-> (state_ff == ST_RUN && halted_n))
    else $error("accepted interrupt did not release halt");

  a_wake_restart: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == ST_SLEEP && wake) |=> (gate.osc && (gate.cpu || state_ff == ST_WARMUP)))
    else $error("stopped clock not restarted");

  a_warm_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == ST_WARMUP) |-> (!gate.clock_out && !gate.cpu && gate.osc))
    else $error("clock released during warm-up");

  a_warm_end: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == ST_WARMUP && warm_cnt_ff == 15'(WARMUP_CYCLES - 1)) |=> (state_ff == ST_NOP))
    else $error("warm-up count ended at wrong cycle");

  a_nop_resleep: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == ST_NOP && t4_strobe && !wake) |=> (state_ff == ST_SLEEP ##0 !gate.cpu))
    else $error("no re-entry into sleep after idle no-op");

endmodule // hpm_top
